// >>> hdl/lcd_ctrl_pkg.sv
package lcd_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_ADDR = 8'h28;
  localparam logic [7:0] STATUS_ADDR = 8'h2C;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int SEG_COUNT = 32;
  localparam int COM_COUNT = 4;
  localparam int DATA_BITS = SEG_COUNT * COM_COUNT;

  // Divider lengths for the high and low frequency chains
  localparam int HF_STAGES = 17;
  localparam int LF_STAGES = 9;

  // Boost clock exponents
  localparam int HF_BOOST0 = 13;
  localparam int HF_BOOST1 = 11;
  localparam int HF_BOOST2 = 10;
  localparam int HF_BOOST3 = 9;
  localparam int LF_BOOST0 = 5;
  localparam int LF_BOOST1 = 3;
  localparam int LF_BOOST2 = 2;

  // Base exponents less two: the slot clock runs at four times the base
  localparam int SLOT_SHIFT = 2;
  localparam int HF_BASE0 = 17 - SLOT_SHIFT;
  localparam int HF_BASE1 = 16 - SLOT_SHIFT;
  localparam int HF_BASE2 = 15 - SLOT_SHIFT;
  localparam int HF_BASE3 = 13 - SLOT_SHIFT;
  localparam int LF_BASE0 = 9 - SLOT_SHIFT;
  localparam int LF_BASE1 = 8 - SLOT_SHIFT;

  // Slots per frame for each drive method
  localparam logic [2:0] SLOTS_QUARTER = 3'h4;
  localparam logic [2:0] SLOTS_THIRD = 3'h3;
  localparam logic [2:0] SLOTS_HALF = 3'h2;
  localparam logic [2:0] SLOTS_STATIC = 3'h4;

  typedef enum logic [1:0] {
    DRIVE_QUARTER = 2'h0,
    DRIVE_THIRD = 2'h1,
    DRIVE_HALF = 2'h2,
    DRIVE_STATIC = 2'h3
  } drive_t;

  typedef struct packed {
    logic display_on_bit;
    logic booster_select_bit;
    logic [1:0] boost_clock_select;
    drive_t drive_method;
    logic [1:0] frame_base_select;
  } ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;

endpackage

// >>> hdl/lcd_driver_control.sv
`timescale 1ns/10ps
`default_nettype none

module lcd_driver_control (
  input wire logic clock,
  input wire logic rst_b,
  input wire lcd_ctrl_pkg::av_req_t av_req,
  output logic [lcd_ctrl_pkg::DATA_W-1:0] av_readdata,
  output logic av_waitrequest,
  input wire logic high_freq_clock,
  input wire logic low_freq_clock,
  input wire logic low_speed_modes,
  input wire logic prescale_source_select,
  input wire logic [lcd_ctrl_pkg::DATA_BITS-1:0] display_data,
  output logic [lcd_ctrl_pkg::COM_COUNT-1:0] common_outputs,
  output logic [lcd_ctrl_pkg::SEG_COUNT-1:0] segment_outputs,
  output logic frame_polarity,
  output logic booster_enable,
  output logic boost_tick
);

  lcd_ctrl_pkg::ctrl_t ctrl;
  logic ack;
  logic access;
  logic [lcd_ctrl_pkg::HF_STAGES:1] hf_tick;
  logic [lcd_ctrl_pkg::LF_STAGES:1] lf_tick;
  logic use_lf;
  logic slot_tick;
  logic next_boost;
  logic [1:0] slot;
  logic [2:0] slot_limit;
  logic frame_end;
  logic slot_over;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer
  assign access = av_req.read | av_req.write;
  assign av_waitrequest = access & ~ack;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ack <= 1'b0;
    else
      ack <= access & ~ack;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ctrl <= lcd_ctrl_pkg::CTRL_RESET;
    else if (av_req.write && ack && av_req.byteenable[0]
             && av_req.address == lcd_ctrl_pkg::CTRL_ADDR)
      ctrl <= av_req.writedata[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      av_readdata <= '0;
    else if (av_req.read && !ack)
    begin
      if (av_req.address == lcd_ctrl_pkg::CTRL_ADDR)
        av_readdata <= {24'h000000, ctrl};
      else if (av_req.address == lcd_ctrl_pkg::STATUS_ADDR)
        av_readdata <= {28'h0000000, low_speed_modes, frame_polarity, slot};
      else
        av_readdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated dividers
  lcd_prescaler #(.STAGES(lcd_ctrl_pkg::HF_STAGES)) hf_div (
    .clock(clock),
    .rst_b(rst_b),
    .count_tick(high_freq_clock),
    .stage_tick(hf_tick)
  );

  lcd_prescaler #(.STAGES(lcd_ctrl_pkg::LF_STAGES)) lf_div (
    .clock(clock),
    .rst_b(rst_b),
    .count_tick(low_freq_clock),
    .stage_tick(lf_tick)
  );

  assign use_lf = low_speed_modes | prescale_source_select;

  ////////////////////////////////////////////////////////////////////////////
  // Boost clock tap
  always_comb
  begin
    next_boost = 1'b0;
    unique case (ctrl.boost_clock_select)
      2'h0: next_boost = use_lf ? lf_tick[lcd_ctrl_pkg::LF_BOOST0]
                                : hf_tick[lcd_ctrl_pkg::HF_BOOST0];
      2'h1: next_boost = use_lf ? lf_tick[lcd_ctrl_pkg::LF_BOOST1]
                                : hf_tick[lcd_ctrl_pkg::HF_BOOST1];
      2'h2: next_boost = use_lf ? lf_tick[lcd_ctrl_pkg::LF_BOOST2]
                                : hf_tick[lcd_ctrl_pkg::HF_BOOST2];
      2'h3: next_boost = low_speed_modes ? lf_tick[lcd_ctrl_pkg::LF_BOOST2]
                                         : hf_tick[lcd_ctrl_pkg::HF_BOOST3];
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      boost_tick <= 1'b0;
    else
      boost_tick <= next_boost & ctrl.booster_select_bit;
  end

  assign booster_enable = ctrl.booster_select_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Slot clock at four times the frame base
  always_comb
  begin
    slot_tick = 1'b0;
    unique case (ctrl.frame_base_select)
      2'h0: slot_tick = use_lf ? lf_tick[lcd_ctrl_pkg::LF_BASE0]
                               : hf_tick[lcd_ctrl_pkg::HF_BASE0];
      2'h1: slot_tick = use_lf ? lf_tick[lcd_ctrl_pkg::LF_BASE1]
                               : hf_tick[lcd_ctrl_pkg::HF_BASE1];
      2'h2: slot_tick = low_speed_modes ? lf_tick[lcd_ctrl_pkg::LF_BASE1]
                                        : hf_tick[lcd_ctrl_pkg::HF_BASE2];
      2'h3: slot_tick = low_speed_modes ? lf_tick[lcd_ctrl_pkg::LF_BASE1]
                                        : hf_tick[lcd_ctrl_pkg::HF_BASE3];
    endcase
  end

  always_comb
  begin
    slot_limit = lcd_ctrl_pkg::SLOTS_QUARTER;
    unique case (ctrl.drive_method)
      lcd_ctrl_pkg::DRIVE_QUARTER: slot_limit = lcd_ctrl_pkg::SLOTS_QUARTER;
      lcd_ctrl_pkg::DRIVE_THIRD: slot_limit = lcd_ctrl_pkg::SLOTS_THIRD;
      lcd_ctrl_pkg::DRIVE_HALF: slot_limit = lcd_ctrl_pkg::SLOTS_HALF;
      lcd_ctrl_pkg::DRIVE_STATIC: slot_limit = lcd_ctrl_pkg::SLOTS_STATIC;
    endcase
  end

  assign frame_end = slot_tick && ({1'b0, slot} >= slot_limit - 3'h1);

  // A shorter duty written mid-frame leaves the slot past the frame: restart it
  assign slot_over = ({1'b0, slot} >= slot_limit);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      slot <= 2'h0;
    else if (frame_end || slot_over)
      slot <= 2'h0;
    else if (slot_tick)
      slot <= slot + 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      frame_polarity <= 1'b0;
    else if (frame_end)
      frame_polarity <= ~frame_polarity;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: selected common and its segment data
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      common_outputs <= '0;
    else if (!ctrl.display_on_bit)
      common_outputs <= '0;
    else if (ctrl.drive_method == lcd_ctrl_pkg::DRIVE_STATIC)
      common_outputs <= '1;
    else if (slot_over)
      common_outputs <= '0;
    else
      common_outputs <= 4'h1 << slot;
  end

  genvar s;
  generate
    for (s = 0; s < lcd_ctrl_pkg::SEG_COUNT; s++)
    begin : g_seg
      always_ff @(posedge clock)
      begin
        if (!rst_b)
          segment_outputs[s] <= 1'b0;
        else if (!ctrl.display_on_bit)
          segment_outputs[s] <= 1'b0;
        else
          segment_outputs[s] <= display_data[{slot, 5'h00} + s];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence ctrl_write_s;
    av_req.write && !av_waitrequest && av_req.byteenable[0]
      && av_req.address == lcd_ctrl_pkg::CTRL_ADDR;
  endsequence

  reset_clear_a: assert property ($rose(rst_b) |-> ctrl == lcd_ctrl_pkg::CTRL_RESET)
    else $error("control not cleared by reset");
  reg_write_a: assert property (ctrl_write_s |=> ctrl == $past(av_req.writedata[7:0]))
    else $error("control write lost");
  wait_once_a: assert property (av_waitrequest |=> !av_waitrequest)
    else $error("waitrequest held too long");
  blank_pins_a: assert property (!ctrl.display_on_bit |=> common_outputs == 4'h0
      && segment_outputs == 32'h00000000)
    else $error("pins driven while blanked");
  third_coms_a: assert property (ctrl.display_on_bit
      && ctrl.drive_method == lcd_ctrl_pkg::DRIVE_THIRD |=> !common_outputs[3])
    else $error("fourth common used at third duty");
  half_coms_a: assert property (ctrl.display_on_bit
      && ctrl.drive_method == lcd_ctrl_pkg::DRIVE_HALF |=> common_outputs[3:2] == 2'h0)
    else $error("upper commons used at half duty");
  static_coms_a: assert property (ctrl.display_on_bit
      && ctrl.drive_method == lcd_ctrl_pkg::DRIVE_STATIC |=> common_outputs == 4'hF)
    else $error("static drive lost a common");
  boost_gate_a: assert property (!ctrl.booster_select_bit |=> !boost_tick)
    else $error("boost clock while booster off");
  frame_flip_a: assert property (frame_end |=> frame_polarity != $past(frame_polarity))
    else $error("polarity did not flip at frame end");
  slot_range_a: assert property ({1'b0, slot} < slot_limit
      || $changed(ctrl.drive_method) || $past(ctrl.drive_method) != ctrl.drive_method)
    else $error("slot beyond duty");

endmodule

`default_nettype wire

// >>> hdl/lcd_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module lcd_prescaler #(
  parameter int STAGES = 17
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic count_tick,
  output logic [STAGES:1] stage_tick
);

  logic [STAGES-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running divider, never stopped by a processor halt
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      count <= '0;
    else if (count_tick)
      count <= count + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One pulse per 2^k input ticks
  genvar k;
  generate
    for (k = 1; k <= STAGES; k++)
    begin : g_stage
      assign stage_tick[k] = count_tick & (&count[k-1:0]);
    end
  endgenerate

endmodule

`default_nettype wire

// >>> test/lcd_panel_model.sv
`timescale 1ns/10ps
`default_nettype none

module lcd_panel_model (
  input wire logic [3:0] common_outputs,
  input wire logic [31:0] segment_outputs,
  output logic [31:0] lit
);
  // A segment lights only while some common row is selected
  assign lit = segment_outputs & {32{|common_outputs}};
endmodule

`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  lcd_ctrl_pkg::av_req_t av_req = '0;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  logic lf_tick = 1'b0;
  logic slow = 1'b0;
  logic src = 1'b0;
  logic [127:0] data = '0;
  logic [3:0] coms;
  logic [31:0] segs;
  logic [31:0] lit;
  logic pol;
  logic booster_en;
  logic boost;
  logic boost_tog = 1'b0;
  logic [31:0] q;
  logic [31:0] s;
  logic [7:0] v;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 65;
  int n;

  //////////////////////////////////////////////////////////////////////////////
  lcd_driver_control i_dut (
    .clock(clock), .rst_b(rst_b), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .high_freq_clock(1'b1), .low_freq_clock(lf_tick),
    .low_speed_modes(slow), .prescale_source_select(src), .display_data(data),
    .common_outputs(coms), .segment_outputs(segs), .frame_polarity(pol),
    .booster_enable(booster_en), .boost_tick(boost)
  );
  lcd_panel_model i_panel (.common_outputs(coms), .segment_outputs(segs), .lit(lit));

  always #2 clock = ~clock;

  // Slow clock pulses every second cycle; boost pulses fold into a toggle
  always @(posedge clock)
  begin
    lf_tick <= ~lf_tick;
    if (boost)
      boost_tog <= ~boost_tog;
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic int boost_cyc(logic [1:0] c, logic f);
    if (f && c != 2'h3)
      return 2 << (c == 2'h0 ? 5 : c == 2'h1 ? 3 : 2);
    return 1 << (c == 2'h0 ? 13 : c == 2'h1 ? 11 : c == 2'h2 ? 10 : 9);
  endfunction

  function automatic int frame_cyc(logic [7:0] r, logic f);
    int b;
    b = (f && !r[1]) ? 2 << (r[0] ? 8 : 9) : 1 << (r[1:0] == 2'h3 ? 13 : 17 - r[1:0]);
    return r[3:2] == 2'h1 ? b * 3 / 4 : r[3:2] == 2'h2 ? b / 2 : b;
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(logic [7:0] a, logic w, logic [31:0] d, logic [3:0] be);
    av_req <= '{a, !w, w, d, be};
    do @(posedge clock); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clock);
  endtask

  // Cycles between two changes of the frame or boost toggle; the first
  // change may stem from the old setting and is skipped
  task automatic measure(logic sel, output int cnt);
    logic last;
    last = sel ? pol : boost_tog;
    cnt = 0;
    repeat (2)
    begin
      @(posedge clock);
      while ((sel ? pol : boost_tog) === last)
        @(posedge clock);
      last = ~last;
    end
    while ((sel ? pol : boost_tog) === last)
    begin
      @(posedge clock);
      cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    bus(8'h28, 1'b0, 32'h0, 4'hF);
    chk(q, 32'h0);
    chk(lit, 32'h0);
    repeat (8)
    begin
      v = $random(seed);
      if (v[6])
        v[3] = 1'b0;
      bus(8'h28, 1'b1, {24'h0, v}, 4'h1);
      bus(8'h28, 1'b0, 32'h0, 4'hF);
      chk(q, {24'h0, v});
      chk(booster_en, v[6]);
    end
    bus(8'h30, 1'b1, 32'hFF, 4'hF);
    bus(8'h30, 1'b0, 32'h0, 4'hF);
    chk(q, 32'h0);
    bus(8'h28, 1'b1, 32'h5A, 4'hE);
    bus(8'h28, 1'b0, 32'h0, 4'hF);
    chk(q, {24'h0, v});
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    bus(8'h28, 1'b0, 32'h0, 4'hF);
    chk(q, 32'h0);
    s = $random(seed);
    data <= {4{s}};
    bus(8'h28, 1'b1, 32'h8F, 4'h1);
    repeat (4) @(posedge clock);
    chk(coms, 4'hF);
    chk(segs, s);
    bus(8'h28, 1'b1, 32'h83, 4'h1);
    repeat (4) @(posedge clock);
    chk($countones(coms), 1);
    chk(lit, s);
    bus(8'h28, 1'b1, 32'h03, 4'h1);
    repeat (4) @(posedge clock);
    chk(lit, 32'h0);
    chk(coms, 4'h0);
    for (int i = 0; i < 11; i++)
    begin
      src <= (i >= 4 && i < 8);
      slow <= (i >= 8);
      bus(8'h28, 1'b1, {24'h0, 2'b01, i[1:0], 4'h0}, 4'h1);
      measure(1'b0, n);
      chk(n, boost_cyc(i[1:0], i >= 4));
    end
    src <= 1'b0;
    for (int j = 0; j < 4; j++)
    begin
      bus(8'h28, 1'b1, {24'h0, 4'h8, j[1:0], 2'b01}, 4'h1);
      measure(1'b1, n);
      chk(n, frame_cyc({4'h8, j[1:0], 2'b01}, 1'b1));
    end
    bus(8'h2C, 1'b0, 32'h0, 4'hF);
    chk(q[31:3], 29'h1);
    slow <= 1'b0;
    bus(8'h28, 1'b1, 32'h83, 4'h1);
    measure(1'b1, n);
    chk(n, frame_cyc(8'h83, 1'b0));
    give_verdict();
  end
endmodule

`default_nettype wire
